// [hdl/aoi_angle_outputs.sv]
`timescale 1ns/1ps
`default_nettype none
module aoi_angle_outputs #(
  parameter int TIMEOUT_CYC = aoi_pkg::TIMEOUT_CYC,
  parameter int PWM_MIN_CYC = aoi_pkg::PWM_MIN_CYC,
  parameter int PWM_STEP_CYC = aoi_pkg::PWM_STEP_CYC,
  parameter int PULSE_CYC = aoi_pkg::PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic interface_select_pin,
  input wire logic serial_clock_in,
  input wire logic serial_data_io_i,
  output logic serial_data_io_o,
  output logic serial_data_io_oe,
  input wire logic select_in,
  output logic chain_select_out,
  input wire logic [8:0] angle_in,
  input wire logic angle_valid,
  input wire logic [5:0] field_code,
  input wire logic lock_in,
  input wire logic [15:0] config_word,
  output logic wr_strobe,
  output logic [4:0] wr_cmd,
  output logic [15:0] wr_data,
  output logic pwm_out,
  output logic inc_a,
  output logic inc_b,
  output logic inc_i,
  output logic comm_u,
  output logic comm_v,
  output logic comm_w
);

  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << aoi_pkg::TO_W) ||
      PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
    $error("aoi_angle_outputs: count parameter out of range");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // (a - b) modulo one turn, both operands below 360
  function automatic logic [8:0] aoi_wrap_sub(input logic [8:0] a,
                                               input logic [8:0] b);
    logic [9:0] d;
    d = {1'b0, a} + aoi_pkg::ANGLE_MOD - {1'b0, b};
    if (d >= aoi_pkg::ANGLE_MOD) begin
      d = d - aoi_pkg::ANGLE_MOD;
    end
    return d[8:0];
  endfunction

  // commutation sector 0..5 of the electrical angle
  function automatic logic [2:0] aoi_sector(input logic [8:0] ang,
                                             input logic [2:0] code);
    int e;
    e = (int'(ang) * (int'(code) + 1)) % aoi_pkg::ANGLE_STEPS;
    return 3'(e / aoi_pkg::SECTOR_DEG);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff; // serial clock, s3 for edges
  logic dat_s1_ff, dat_s2_ff; // serial data in
  logic sel_s1_ff, sel_s2_ff, sel_s3_ff; // select, s3 for edges
  logic mode_s1_ff, mode_s2_ff; // interface select strap

  // the first stage of each chain feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {clk_s1_ff, clk_s2_ff, clk_s3_ff} <= 3'h0;
      {dat_s1_ff, dat_s2_ff} <= 2'h0;
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <= 3'h0;
      {mode_s1_ff, mode_s2_ff} <= 2'h0;
    end else begin
      {clk_s1_ff, clk_s2_ff, clk_s3_ff} <=
        {serial_clock_in, clk_s1_ff, clk_s2_ff};
      {dat_s1_ff, dat_s2_ff} <= {serial_data_io_i, dat_s1_ff};
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <=
        {select_in, sel_s1_ff, sel_s2_ff};
      {mode_s1_ff, mode_s2_ff} <= {interface_select_pin, mode_s1_ff};
    end
  end

  wire rise = clk_s2_ff & ~clk_s3_ff; // serial clock rising edge
  wire fall = ~clk_s2_ff & clk_s3_ff; // serial clock falling edge
  wire sel_rise = sel_s2_ff & ~sel_s3_ff;
  wire two_wire = mode_s2_ff;

  // ---------------------------------------------------------------
  // two-wire clock timeout
  // ---------------------------------------------------------------
  logic [aoi_pkg::TO_W-1:0] to_cnt_ff; // cycles since last rising edge
  wire to_hit = ~rise &&
    (to_cnt_ff == aoi_pkg::TO_W'(TIMEOUT_CYC - 1)); // one-cycle pulse
  wire to_sat = (to_cnt_ff == aoi_pkg::TO_W'(TIMEOUT_CYC));

  // counter saturates so a stopped clock gives one reset, not many
  always_ff @(posedge sys_clk) begin
    if (!rstn || rise) begin
      to_cnt_ff <= '0;
    end else if (!to_sat) begin
      to_cnt_ff <= to_cnt_ff + aoi_pkg::TO_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // angle path
  // ---------------------------------------------------------------
  logic [8:0] ang_ff; // zero-corrected angle
  logic [8:0] ang_prev_ff; // previous corrected angle
  logic valid_ff; // registered validity
  wire [8:0] zero_angle = config_word[aoi_pkg::ZERO_LSB +: 9];
  wire [2:0] uvw_code = config_word[aoi_pkg::UVW_LSB +: 3];
  wire aoi_pkg::aoi_abi_t abi_mode =
    aoi_pkg::aoi_abi_t'(config_word[aoi_pkg::ABI_LSB +: 2]);
  wire uvw_off = (uvw_code > aoi_pkg::UVW_MAX_CODE);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ang_ff <= 9'h000;
      ang_prev_ff <= 9'h000;
      valid_ff <= 1'b0;
    end else begin
      ang_ff <= aoi_wrap_sub(angle_in, zero_angle);
      ang_prev_ff <= ang_ff;
      valid_ff <= angle_valid;
    end
  end

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  aoi_pkg::aoi_ser_st_t st_ff, nxt_st; // transfer phase
  logic [4:0] cnt_ff, nxt_cnt; // bit index within a phase
  logic [4:0] cmd_ff, nxt_cmd; // command shift register
  logic [15:0] sh_ff, nxt_sh; // data shift register
  logic rw_ff, nxt_rw; // first command bit: 1 = write
  logic oe_ff, nxt_oe; // data pin driven
  logic nxt_wr_stb; // write word complete
  logic chain_ff, nxt_chain; // chain select output
  logic wr_stb_ff; // write strobe
  logic [4:0] wr_cmd_ff; // write command
  logic [15:0] wr_data_ff; // write data

  // three-wire: select low holds reset; two-wire: timeout resets
  wire if_reset = two_wire ? to_hit : ~sel_s2_ff;
  wire start = two_wire ? 1'b1 : sel_rise;
  wire [4:0] cmd_full = {cmd_ff[3:0], dat_s2_ff};
  // only the angle read is served here; other reads return zeros
  wire is_angle_cmd = (cmd_full == aoi_pkg::CMD_READ_ANGLE);
  wire [15:0] rd_word = is_angle_cmd ?
    {lock_in, field_code, ang_ff} : 16'h0000;
  wire enter_done = (nxt_st == aoi_pkg::ST_DONE) &&
    (st_ff != aoi_pkg::ST_DONE);

  // next-state logic; host shifts on rising edges, device changes its
  // data after each rising edge so the host can sample on falling
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_sh = sh_ff;
    nxt_rw = rw_ff;
    nxt_oe = oe_ff;
    nxt_wr_stb = 1'b0;
    if (if_reset) begin
      nxt_st = aoi_pkg::ST_IDLE;
      nxt_cnt = 5'h00;
      nxt_oe = 1'b0;
    end else begin
      unique case (st_ff)
        aoi_pkg::ST_IDLE: begin
          if (start) begin
            nxt_st = aoi_pkg::ST_CMD;
            nxt_cnt = 5'h00;
          end
        end
        aoi_pkg::ST_CMD: begin
          if (rise) begin
            nxt_cmd = cmd_full;
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == 5'h00) begin
              nxt_rw = dat_s2_ff;
            end
            if (cnt_ff == aoi_pkg::CMD_LAST) begin
              nxt_cnt = 5'h00;
              if (rw_ff) begin
                nxt_st = aoi_pkg::ST_WDATA;
              end else begin
                nxt_st = aoi_pkg::ST_RDATA;
                nxt_sh = rd_word;
                nxt_oe = 1'b1;
              end
            end
          end
        end
        aoi_pkg::ST_RDATA: begin
          if (rise) begin
            nxt_sh = {sh_ff[14:0], 1'b0}; // msb first
            nxt_cnt = cnt_ff + 5'h01;
          end else if (fall && cnt_ff == aoi_pkg::DATA_LAST) begin
            nxt_st = aoi_pkg::ST_DONE; // host has taken the last bit
            nxt_oe = 1'b0;
          end
        end
        aoi_pkg::ST_WDATA: begin
          if (rise) begin
            nxt_sh = {sh_ff[14:0], dat_s2_ff};
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == aoi_pkg::DATA_LAST) begin
              nxt_st = aoi_pkg::ST_DONE;
              nxt_wr_stb = 1'b1;
            end
          end
        end
        aoi_pkg::ST_DONE: begin
          nxt_st = aoi_pkg::ST_DONE; // wait for select low or timeout
        end
        default: begin
          nxt_st = aoi_pkg::ST_IDLE; // illegal one-hot code recovers
        end
      endcase
    end
  end

  // daisy-chain select; end of frame beats the falling-edge set
  always_comb begin
    nxt_chain = chain_ff;
    if (!two_wire) begin
      if (!sel_s2_ff) begin
        nxt_chain = 1'b0;
      end else if (enter_done) begin
        nxt_chain = 1'b1;
      end
    end else if (to_hit || enter_done) begin
      nxt_chain = 1'b0;
    end else if (fall && st_ff == aoi_pkg::ST_CMD) begin
      nxt_chain = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_ff <= aoi_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
      cmd_ff <= 5'h00;
      sh_ff <= 16'h0000;
      rw_ff <= 1'b0;
      oe_ff <= 1'b0;
      chain_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      sh_ff <= nxt_sh;
      rw_ff <= nxt_rw;
      oe_ff <= nxt_oe;
      chain_ff <= nxt_chain;
    end
  end

  // write word hand-off to the command logic outside
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_stb_ff <= 1'b0;
      wr_cmd_ff <= 5'h00;
      wr_data_ff <= 16'h0000;
    end else begin
      wr_stb_ff <= nxt_wr_stb;
      if (nxt_wr_stb) begin
        wr_cmd_ff <= cmd_ff;
        wr_data_ff <= nxt_sh;
      end
    end
  end

  // ---------------------------------------------------------------
  // incremental and commutation outputs
  // ---------------------------------------------------------------
  logic dir_ff; // 1 = clockwise (angle rising)
  logic [7:0] pls_cnt_ff; // fixed-width pulse timer
  logic inc_a_ff, inc_b_ff, inc_i_ff, u_ff, v_ff, w_ff;
  wire moved = (ang_ff != ang_prev_ff);
  wire cw_step = aoi_wrap_sub(ang_ff, ang_prev_ff) < aoi_pkg::HALF_TURN;
  wire pls_on = (pls_cnt_ff != 8'h00);
  // gray sequence 00,10,11,01 on rising angle: A leads B
  wire quad_a = ang_ff[0] ^ ang_ff[1];
  wire quad_b = ang_ff[1];
  wire index = (ang_ff == 9'h000);
  wire [2:0] sector = aoi_sector(ang_ff, uvw_code);
  wire nxt_inc_a = (abi_mode == aoi_pkg::ABI_QUAD) ? quad_a :
                   (abi_mode == aoi_pkg::ABI_STEP) ? ang_ff[0] :
                   (abi_mode == aoi_pkg::ABI_PULSE) ? pls_on :
                   1'b0;
  wire nxt_inc_b = (abi_mode == aoi_pkg::ABI_QUAD) ? quad_b :
                   (abi_mode == aoi_pkg::ABI_OFF) ? 1'b0 :
                   dir_ff;
  wire nxt_inc_i = (abi_mode != aoi_pkg::ABI_OFF) && index;
  // three 180-degree windows spaced 120 degrees apart
  wire nxt_u = !uvw_off && (sector <= 3'h2);
  wire nxt_v = !uvw_off && (sector >= 3'h2) && (sector <= 3'h4);
  wire nxt_w = !uvw_off && ((sector >= 3'h4) || (sector == 3'h0));

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dir_ff <= 1'b1;
      pls_cnt_ff <= 8'h00;
      {inc_a_ff, inc_b_ff, inc_i_ff} <= 3'h0;
      {u_ff, v_ff, w_ff} <= 3'h0;
    end else begin
      if (moved) begin
        dir_ff <= cw_step;
        pls_cnt_ff <= 8'(PULSE_CYC);
      end else if (pls_on) begin
        pls_cnt_ff <= pls_cnt_ff - 8'h01;
      end
      {inc_a_ff, inc_b_ff, inc_i_ff} <= {nxt_inc_a, nxt_inc_b, nxt_inc_i};
      {u_ff, v_ff, w_ff} <= {nxt_u, nxt_v, nxt_w};
    end
  end

  // ---------------------------------------------------------------
  // pwm generator
  // ---------------------------------------------------------------
  aoi_angle_if ang_bus ();
  assign ang_bus.angle = ang_ff;
  assign ang_bus.valid = valid_ff;
  assign ang_bus.off = uvw_off;

  aoi_pwm_gen #(.MIN_CYC(PWM_MIN_CYC), .STEP_CYC(PWM_STEP_CYC)) u_pwm (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ang(ang_bus),
    .pwm_out(pwm_out)
  );

  assign serial_data_io_o = sh_ff[15];
  assign serial_data_io_oe = oe_ff;
  assign chain_select_out = chain_ff;
  assign wr_strobe = wr_stb_ff;
  assign wr_cmd = wr_cmd_ff;
  assign wr_data = wr_data_ff;
  assign {inc_a, inc_b, inc_i} = {inc_a_ff, inc_b_ff, inc_i_ff};
  assign {comm_u, comm_v, comm_w} = {u_ff, v_ff, w_ff};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_cmd_last;
    rise && st_ff == aoi_pkg::ST_CMD && cnt_ff == aoi_pkg::CMD_LAST;
  endsequence

  AST_TWO_WIRE_NO_SEL: assert property (
    two_wire && !to_hit && st_ff == aoi_pkg::ST_RDATA && !sel_s2_ff
      |=> st_ff != aoi_pkg::ST_IDLE) else $error("select used in two-wire");
  AST_SEL_RESET: assert property (
    !two_wire && !sel_s2_ff |=> st_ff == aoi_pkg::ST_IDLE && !oe_ff)
    else $error("three-wire not reset by select low");
  AST_FRAME_LOAD: assert property (
    s_cmd_last and (##0 !rw_ff && !if_reset)
      |=> serial_data_io_oe && sh_ff == $past(rd_word))
    else $error("read word not loaded");
  AST_CMD_ZERO: assert property (
    s_cmd_last and (##0 !rw_ff && !if_reset && cmd_full == 5'h00)
      |=> sh_ff[8:0] == $past(ang_ff) && sh_ff[15] == $past(lock_in))
    else $error("zero command not decoded as angle read");
  AST_WRITE_PATH: assert property (
    s_cmd_last and (##0 rw_ff && !if_reset)
      |=> st_ff == aoi_pkg::ST_WDATA && !serial_data_io_oe)
    else $error("write command drove the data pin");
  AST_TIMEOUT: assert property (
    two_wire && to_hit |=> st_ff == aoi_pkg::ST_IDLE && !chain_select_out)
    else $error("timeout did not reset interface");
  AST_CHAIN3: assert property (
    !two_wire && sel_s2_ff && enter_done |=> chain_select_out [*2])
    else $error("chain output missing at cycle end");
  AST_CHAIN2: assert property (
    two_wire && !to_hit && fall && st_ff == aoi_pkg::ST_CMD
      |=> chain_select_out) else $error("chain output not set on fall");
  AST_SYNC: assert property (
    rise |-> $past(serial_clock_in, 2) && !$past(serial_clock_in, 3))
    else $error("clock edge not two stages late");
  AST_ABI_OFF: assert property (
    abi_mode == aoi_pkg::ABI_OFF |=> !inc_a && !inc_b && !inc_i)
    else $error("incremental pins not low when off");
  AST_UVW_OFF: assert property (
    uvw_off |=> !comm_u && !comm_v && !comm_w)
    else $error("commutation pins not low when off");
endmodule
`default_nettype wire

// [hdl/aoi_pkg.sv]
`default_nettype none
package aoi_pkg;

  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int CMD_BITS = 5; // command field width
  localparam int DATA_BITS = 16; // data field width
  localparam int FRAME_BITS = CMD_BITS + DATA_BITS; // 21-bit frame
  localparam logic [4:0] CMD_READ_ANGLE = 5'h00; // all-zero command
  localparam logic [4:0] CMD_LAST = 5'h04; // index of last command bit
  localparam logic [4:0] DATA_LAST = 5'h0f; // index of last data bit

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // sys_clk period
  localparam int TIMEOUT_US = 20; // two-wire clock timeout
  localparam int TIMEOUT_CYC =
    (TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TO_W = 12; // timeout counter width
  localparam int PWM_MIN_NS = 1000; // least high time of the pwm
  localparam int PWM_MIN_CYC =
    (PWM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_STEP_NS = 1000; // high time added per degree
  localparam int PWM_STEP_CYC =
    (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_NS = 500; // width of one incremental pulse
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // angle arithmetic and configuration word fields
  // ---------------------------------------------------------------
  localparam int ANGLE_STEPS = 360; // positions per turn
  localparam logic [9:0] ANGLE_MOD = 10'h168; // 360 at adder width
  localparam logic [8:0] HALF_TURN = 9'h0b4; // 180 degrees
  localparam int SECTOR_DEG = 60; // one commutation step
  localparam int ABI_LSB = 12; // incremental mode field 13:12
  localparam int UVW_LSB = 9; // pole pair field 11:9
  localparam int ZERO_LSB = 0; // zero angle field 8:0
  localparam logic [2:0] UVW_MAX_CODE = 3'h5; // six pole pairs

  typedef enum logic [1:0] {
    ABI_QUAD = 2'h0,
    ABI_STEP = 2'h1,
    ABI_PULSE = 2'h2,
    ABI_OFF = 2'h3
  } aoi_abi_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_RDATA = 5'h04,
    ST_WDATA = 5'h08,
    ST_DONE = 5'h10
  } aoi_ser_st_t;

endpackage
`default_nettype wire

// [hdl/aoi_angle_if.sv]
`timescale 1ns/1ps
`default_nettype none
// angle path from the serial/angle core to the pwm generator
interface aoi_angle_if;
  logic [8:0] angle; // zero-corrected angle
  logic valid; // angle data usable
  logic off; // commutation field says outputs off
  modport src (output angle, output valid, output off);
  modport snk (input angle, input valid, input off);
endinterface
`default_nettype wire

// [hdl/aoi_pwm_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module aoi_pwm_gen #(
  parameter int MIN_CYC = aoi_pkg::PWM_MIN_CYC,
  parameter int STEP_CYC = aoi_pkg::PWM_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  aoi_angle_if.snk ang,
  output logic pwm_out
);
  // low time never drops under the minimum either, so a filter sees
  // clean edges at both ends of the range
  localparam int PERIOD = 2 * MIN_CYC + (aoi_pkg::ANGLE_STEPS - 1) * STEP_CYC;
  localparam int CW = 20;

  if (MIN_CYC < 1 || STEP_CYC < 1 || PERIOD >= (1 << CW)) begin : g_chk
    $error("aoi_pwm_gen: pwm timing out of range");
  end

  logic [CW-1:0] cnt_ff; // position inside the period
  logic [CW-1:0] len_ff; // latched high length
  logic [CW-1:0] hi_ff; // length of the running high pulse
  logic pwm_ff; // registered output

  // ---------------------------------------------------------------
  // period decode
  // ---------------------------------------------------------------
  wire period_start = (cnt_ff == '0);
  wire [CW-1:0] nxt_cnt =
    (cnt_ff == CW'(PERIOD - 1)) ? '0 : cnt_ff + CW'(1);
  wire [CW-1:0] nxt_len =
    CW'(MIN_CYC) + CW'(ang.angle) * CW'(STEP_CYC);
  wire [CW-1:0] cur_len = period_start ? nxt_len : len_ff;
  // invalid data or commutation off forces the line low at once
  // a pulse may only begin at the period start, so a late valid or a
  // late enable can never leave a sliver shorter than the minimum
  wire nxt_pwm = ang.valid && !ang.off && (cnt_ff < cur_len) &&
    (period_start || pwm_ff);
  wire [CW-1:0] nxt_hi = nxt_pwm ? hi_ff + CW'(1) : '0;

  // ---------------------------------------------------------------
  // period counter, angle latch and output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_ff <= '0;
      len_ff <= '0;
      hi_ff <= '0;
      pwm_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (period_start) begin
        len_ff <= nxt_len;
      end
      hi_ff <= nxt_hi;
      pwm_ff <= nxt_pwm;
    end
  end

  assign pwm_out = pwm_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_PWM_INVALID: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !ang.valid |=> !pwm_out) else $error("pwm high while angle invalid");
  AST_PWM_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !period_start |=> $stable(len_ff))
    else $error("pwm value moved mid period");
  AST_PWM_MIN: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(pwm_out) && $past(ang.valid) && !$past(ang.off)
      |-> $past(hi_ff) >= CW'(MIN_CYC)) else $error("pwm pulse too short");
  AST_PWM_OFF: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ang.off |=> !pwm_out) else $error("pwm high while commutation off");
endmodule
`default_nettype wire

// [verif/aoi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host: serial clock idles low between frames, data held across rises
module aoi_host_model (
  output logic sclk,
  output logic hd,
  output logic h_oe,
  input wire logic din
);
  initial begin
    sclk = 1'b0;
    hd = 1'b0;
    h_oe = 1'b0;
  end
  task automatic xfer(input int n, input logic [4:0] cmd,
                      input logic [15:0] wd, output logic [15:0] rd);
    // 1 ns offset keeps every pin edge clear of a sys_clk rising edge
    #1;
    for (int i = 0; i < n; i++) begin
      h_oe = i < 5 || cmd[4];
      hd = i < 5 ? cmd[4-i] : wd[20-i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      if (i >= 4 && i < 20) rd[19-i] = din;
    end
    h_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_aoi_angle_outputs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_aoi_angle_outputs;
  localparam int TO = 50;
  logic sys_clk = 1'b0, rstn = 1'b0, interface_select_pin = 1'b0;
  logic serial_clock_in, serial_data_io_i, serial_data_io_o;
  logic serial_data_io_oe, select_in = 1'b0, chain_select_out;
  logic [8:0] angle_in = 9'h064;
  logic angle_valid = 1'b1, lock_in = 1'b1, dir, hd, h_oe;
  logic [5:0] field_code = 6'h2a;
  logic [15:0] config_word = 16'h001e, wr_data, rd;
  logic wr_strobe, pwm_out, inc_a, inc_b, inc_i, comm_u, comm_v, comm_w;
  logic [4:0] wr_cmd;
  logic [2:0] e;
  int failures = 0, total_checks = 0, n, k, s, pv = 70;
  always #5 sys_clk = ~sys_clk;
  // data pin has a pull-down when nobody drives it
  assign serial_data_io_i = serial_data_io_oe ? serial_data_io_o :
                            h_oe ? hd : 1'b0;
  aoi_angle_outputs #(.TIMEOUT_CYC(TO), .PWM_MIN_CYC(2), .PWM_STEP_CYC(1),
    .PULSE_CYC(3)) u_aoi_angle_outputs (.sys_clk, .rstn,
    .interface_select_pin, .serial_clock_in, .serial_data_io_i,
    .serial_data_io_o, .serial_data_io_oe, .select_in, .chain_select_out,
    .angle_in, .angle_valid, .field_code, .lock_in, .config_word,
    .wr_strobe, .wr_cmd, .wr_data, .pwm_out, .inc_a, .inc_b, .inc_i,
    .comm_u, .comm_v, .comm_w);
  aoi_host_model u_aoi_host_model (.sclk(serial_clock_in), .hd, .h_oe,
    .din(serial_data_io_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  // a wait that ran out of its bound ends the run
  task automatic lim(input int v);
    if (v >= 800) begin
      failures++;
      final_report;
    end
  endtask
  // counts pwm high cycles over more than one full period
  task automatic quiet(output int q);
    q = 0;
    repeat (400) begin
      cyc(1);
      if (pwm_out !== 1'b0) q++;
    end
  endtask
  task automatic do_reset(input logic two);
    rstn = 1'b0;
    interface_select_pin = two;
    cyc(12);
    rstn = 1'b1;
    cyc(4);
  endtask
  task automatic t_read3;
    do_reset(1'b0);
    select_in = 1'b1;
    cyc(5);
    u_aoi_host_model.xfer(20, 5'h00, 16'h0000, rd);
    chk(rd, {1'b1, 6'h2a, 9'h046});
    cyc(10);
    chk(chain_select_out, 1'b1);
    select_in = 1'b0;
    cyc(6);
    chk(chain_select_out, 1'b0);
    $display("three-wire read finished");
  endtask
  task automatic t_write2;
    do_reset(1'b1);
    fork
      u_aoi_host_model.xfer(21, 5'h17, 16'ha5c3, rd);
      begin
        cyc(20);
        chk(chain_select_out, 1'b1);
        for (n = 0; n < 800 && wr_strobe !== 1'b1; n++) cyc(1);
        lim(n);
        chk({wr_cmd, wr_data[10:0]}, {5'h17, 11'h5c3});
        chk(wr_data, 16'ha5c3);
      end
    join
    cyc(10);
    chk(chain_select_out, 1'b0);
    cyc(TO + 20);
    u_aoi_host_model.xfer(3, 5'h00, 16'h0000, rd);
    cyc(TO + 20);
    chk(chain_select_out, 1'b0);
    u_aoi_host_model.xfer(20, 5'h00, 16'h0000, rd);
    chk(rd, {1'b1, 6'h2a, 9'h046});
    cyc(1);
    $display("two-wire write and timeout finished");
  endtask
  task automatic t_pwm;
    for (k = 0; k < 2; k++) begin
      angle_in = k ? 9'h023 : 9'h01e;
      cyc(2);
      for (n = 0; n < 800 && pwm_out !== 1'b0; n++) cyc(1);
      lim(n);
      for (n = 0; n < 800 && pwm_out !== 1'b1; n++) cyc(1);
      lim(n);
      angle_in = 9'h064;
      for (n = 0; n < 800 && pwm_out === 1'b1; n++) cyc(1);
      chk(n, 2 + 5 * k);
    end
    angle_valid = 1'b0;
    quiet(s);
    chk(s, 0);
    angle_valid = 1'b1;
    $display("pwm finished");
  endtask
  task automatic t_inc;
    for (int m = 0; m < 4; m++) begin
      config_word[13:12] = 2'(m);
      for (int j = 0; j < 5; j++) begin
        k = j == 4 ? 2 : j;
        angle_in = 9'(30 + k);
        cyc(4);
        dir = ((k - pv + 360) % 360) < 180;
        pv = k;
        e[2] = m == 0 ? k == 1 || k == 2 : m == 1 ? k[0] : 1'b1;
        e[1:0] = {m == 0 ? k >= 2 : dir, k == 0};
        if (m == 3) e = 3'h0;
        chk({inc_a, inc_b, inc_i}, e);
        if (m == 2) begin
          cyc(3);
          chk(inc_a, 1'b0);
        end
      end
    end
    $display("incremental finished");
  endtask
  task automatic t_uvw;
    angle_in = 9'h050;
    for (int c = 0; c < 8; c++) begin
      config_word[11:9] = 3'(c);
      cyc(4);
      s = (50 * (c + 1)) % 360 / 60;
      e = c > 5 ? 3'h0 : {s <= 2, s >= 2 && s <= 4, s >= 4 || s == 0};
      chk({comm_u, comm_v, comm_w}, e);
      if (c > 5) begin
        quiet(s);
        chk(s, 0);
      end
    end
    $display("commutation finished");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_read3;
    t_write2;
    t_pwm;
    t_inc;
    t_uvw;
    final_report;
  end
endmodule
`default_nettype wire
